// file: rtl/acr_map.svh
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_CTRL0_ADDR      8'hE8
`define ACR_REFCTL_ADDR     8'hD1
`define ACR_CTRL0_RESET     8'h00
`define ACR_REFCTL_RESET    8'h00
`define ACR_BIT_ENABLE      7
`define ACR_BIT_BURST       6
`define ACR_BIT_DONE        5
`define ACR_BIT_BUSY        4
`define ACR_BIT_WINDOW      3
`define ACR_TRIG_MSB        2
`define ACR_REFSEL_LSB      3
`define ACR_BIT_GNDSEL      2
`define ACR_BIT_INTERNAL_REF_LEVEL     1
`define ACR_BIT_TEMPEN      0
`define ACR_CONV_CYCLES     8'h10
`endif

// file: rtl/acr_pkg.sv
`default_nettype none
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_REF_EXT    = 2'h0,
        ACR_REF_VDD    = 2'h1,
        ACR_REF_VREG   = 2'h2,
        ACR_REF_INT    = 2'h3
    } acr_ref_t;
    typedef enum logic [2:0] {
        ACR_TRG_SW     = 3'h0,
        ACR_TRG_T0     = 3'h1,
        ACR_TRG_T2     = 3'h2,
        ACR_TRG_T3     = 3'h3,
        ACR_TRG_EXT    = 3'h4
    } acr_trig_t;
    typedef enum logic [2:0] {
        ACR_ST_IDLE    = 3'b001,
        ACR_ST_CONV    = 3'b010,
        ACR_ST_DONE    = 3'b100
    } acr_state_t;
    typedef struct packed {
        logic timer0Ovf;
        logic timer2Ovf;
        logic timer3Ovf;
        logic extStart;
    } acr_trig_in_t;
    typedef struct packed {
        logic [1:0] refSel;
        logic       intRefOn;
        logic       intRefHigh;
        logic       useAgndPin;
        logic       useChipGnd;
        logic       tempSensorOn;
    } acr_analog_t;
endpackage
`default_nettype wire

// file: rtl/acr_adc_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"
module acr_adc_control
    import acr_pkg::*;
#(
    parameter int          RES_W       = 16,
    parameter logic [7:0]  CONV_CYCLES = `ACR_CONV_CYCLES,
    parameter logic [6:0]  BURST_LEN   = 7'h04
) (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic [7:0]         sfrAddr,
    input  wire logic [7:0]         sfrWdata,
    input  wire logic               sfrWe,
    output logic [7:0]              sfrRdata_ff,
    input  wire acr_trig_in_t       trigIn,
    input  wire logic               tempSelected,
    input  wire logic [RES_W-1:0]   sampleResult,
    input  wire logic [RES_W-1:0]   windowGt,
    input  wire logic [RES_W-1:0]   windowLt,
    output logic [RES_W-1:0]        result_ff,
    output logic                    convActive_ff,
    output logic                    sampling_ff,
    output acr_analog_t             analog_ff
);
    // ============================================================
    // Registers and state
    logic [7:0]        ctrl_ff, nxt_ctrl;
    logic [7:0]        refCtl_ff, nxt_refCtl;
    acr_state_t        state_ff, nxt_state;
    logic [7:0]        cnt_ff, nxt_cnt;
    logic [6:0]        burst_ff, nxt_burst;
    logic              extPrev_ff, nxt_extPrev;
    logic              nxt_convActive, nxt_sampling;
    logic [RES_W-1:0]  nxt_result;
    logic [7:0]        nxt_rdata;
    acr_analog_t       nxt_analog;
    logic              startReq, convEnd, inWindow, ctrlWr, refWr;
    logic              doneSet, winSet;
    acr_ref_t          refSel;

    assign ctrlWr = sfrWe && (sfrAddr == `ACR_CTRL0_ADDR);
    assign refWr  = sfrWe && (sfrAddr == `ACR_REFCTL_ADDR);
    assign refSel = acr_ref_t'(refCtl_ff[`ACR_REFSEL_LSB +: 2]);

    // ============================================================
    // Trigger selection
    always_comb begin
        case (acr_trig_t'(ctrl_ff[`ACR_TRIG_MSB:0]))
            ACR_TRG_SW:  startReq = ctrlWr && sfrWdata[`ACR_BIT_BUSY];
            ACR_TRG_T0:  startReq = trigIn.timer0Ovf;
            ACR_TRG_T2:  startReq = trigIn.timer2Ovf;
            ACR_TRG_T3:  startReq = trigIn.timer3Ovf;
            ACR_TRG_EXT: startReq = trigIn.extStart && !extPrev_ff;
            default:     startReq = 1'b0;
        endcase
    end

    // ============================================================
    // Window comparator
    // Ordered limits give an inside window; reversed limits an outside one.
    always_comb begin
        if (windowLt > windowGt) begin
            inWindow = (sampleResult > windowGt) && (sampleResult < windowLt);
        end else begin
            inWindow = (sampleResult > windowGt) || (sampleResult < windowLt);
        end
    end

    // ============================================================
    // Conversion sequencer
    // A disabled converter still converts in burst mode, powering up per burst.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_burst = burst_ff;
        convEnd   = 1'b0;
        nxt_extPrev = trigIn.extStart;
        case (state_ff)
            ACR_ST_IDLE: begin
                if (startReq && (ctrl_ff[`ACR_BIT_ENABLE] || ctrl_ff[`ACR_BIT_BURST])) begin
                    nxt_state = ACR_ST_CONV;
                    nxt_cnt   = CONV_CYCLES;
                    nxt_burst = ctrl_ff[`ACR_BIT_BURST] ? BURST_LEN : 7'h01;
                end
            end
            ACR_ST_CONV: begin
                if (cnt_ff == 8'h01) begin
                    convEnd = 1'b1;
                    if (burst_ff == 7'h01) begin
                        nxt_state = ACR_ST_DONE;
                    end else begin
                        nxt_burst = burst_ff - 7'h01;
                        nxt_cnt   = CONV_CYCLES;
                    end
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            ACR_ST_DONE: nxt_state = ACR_ST_IDLE;
            default:     nxt_state = ACR_ST_IDLE;
        endcase
    end

    // ============================================================
    // Register file
    // Hardware set beats a software clear written in the same cycle.
    assign doneSet = (state_ff == ACR_ST_DONE);
    assign winSet  = convEnd && (nxt_state == ACR_ST_DONE) && inWindow;
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_refCtl = refCtl_ff;
        if (ctrlWr) begin
            nxt_ctrl = sfrWdata;
        end
        nxt_ctrl[`ACR_BIT_BUSY] = (nxt_state != ACR_ST_IDLE);
        if (doneSet) begin
            nxt_ctrl[`ACR_BIT_DONE] = 1'b1;
        end
        if (winSet) begin
            nxt_ctrl[`ACR_BIT_WINDOW] = 1'b1;
        end
        if (refWr) begin
            nxt_refCtl = sfrWdata;
        end
        nxt_result = result_ff;
        if (convEnd) begin
            nxt_result = sampleResult;
        end
        case (sfrAddr)
            `ACR_CTRL0_ADDR:  nxt_rdata = nxt_ctrl;
            `ACR_REFCTL_ADDR: nxt_rdata = nxt_refCtl;
            default:          nxt_rdata = 8'h00;
        endcase
    end

    // ============================================================
    // Analog controls
    always_comb begin
        nxt_analog.refSel       = refSel;
        nxt_analog.intRefOn     = (refSel == ACR_REF_INT) && (nxt_state != ACR_ST_IDLE);
        nxt_analog.intRefHigh   = refCtl_ff[`ACR_BIT_INTERNAL_REF_LEVEL];
        nxt_analog.tempSensorOn = refCtl_ff[`ACR_BIT_TEMPEN];
        nxt_analog.useChipGnd   = (tempSelected && nxt_state == ACR_ST_IDLE)
                               || ((refSel == ACR_REF_INT) && !refCtl_ff[`ACR_BIT_INTERNAL_REF_LEVEL]
                                   && nxt_state == ACR_ST_CONV);
        nxt_analog.useAgndPin   = refCtl_ff[`ACR_BIT_GNDSEL] && !nxt_analog.useChipGnd;
        nxt_convActive          = (nxt_state == ACR_ST_CONV);
        nxt_sampling            = (nxt_state == ACR_ST_IDLE);
    end

    // ============================================================
    // Sequencer state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff   <= ACR_ST_IDLE;
            cnt_ff     <= 8'h00;
            burst_ff   <= 7'h00;
            extPrev_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            burst_ff   <= nxt_burst;
            extPrev_ff <= nxt_extPrev;
        end
    end

    // ============================================================
    // Register file state
    // Control resets to zero, so every flag and the trigger code start cleared.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_ff     <= `ACR_CTRL0_RESET;
            refCtl_ff   <= `ACR_REFCTL_RESET;
            result_ff   <= '0;
            sfrRdata_ff <= 8'h00;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            refCtl_ff   <= nxt_refCtl;
            result_ff   <= nxt_result;
            sfrRdata_ff <= nxt_rdata;
        end
    end

    // ============================================================
    // Output state
    // Outputs copy the next-state decode, so they line up with state_ff.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            convActive_ff <= 1'b0;
            sampling_ff   <= 1'b0;
            analog_ff     <= '0;
        end else begin
            convActive_ff <= nxt_convActive;
            sampling_ff   <= nxt_sampling;
            analog_ff     <= nxt_analog;
        end
    end

    // ============================================================
    // Checks
    chk_done_sets: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_DONE) |=> ctrl_ff[`ACR_BIT_DONE])
        else $error("done flag not set after conversion");
    chk_done_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        (ctrl_ff[`ACR_BIT_DONE] && !ctrlWr) |=> ctrl_ff[`ACR_BIT_DONE])
        else $error("done flag cleared without write");
    chk_sw_start: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && ctrl_ff[2:0] == 3'h0 && ctrl_ff[7] && ctrlWr && sfrWdata[4])
        |=> state_ff == ACR_ST_CONV)
        else $error("software start ignored");
    chk_reserved_idle: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && ctrl_ff[2:0] > 3'h4) |=> state_ff == ACR_ST_IDLE)
        else $error("reserved trigger started conversion");
    chk_shutdown: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && !ctrl_ff[7] && !ctrl_ff[6]) |=> state_ff == ACR_ST_IDLE)
        else $error("conversion while shut down");
    chk_intref_auto: assert property (@(posedge ref_clk) disable iff (srst)
        analog_ff.intRefOn |-> (convActive_ff || state_ff == ACR_ST_DONE))
        else $error("internal reference on while idle");
    chk_temp_gnd: assert property (@(posedge ref_clk) disable iff (srst)
        ($past(tempSelected) && sampling_ff) |-> !analog_ff.useAgndPin)
        else $error("analog ground used for temperature sampling");
    chk_window_set: assert property (@(posedge ref_clk) disable iff (srst)
        winSet |=> ctrl_ff[`ACR_BIT_WINDOW])
        else $error("window flag not set");
    chk_conv_len: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && nxt_state == ACR_ST_CONV && !ctrl_ff[6])
        |=> ##15 (state_ff == ACR_ST_CONV) ##1 (state_ff == ACR_ST_DONE))
        else $error("single conversion length wrong");
    // Busy cycles are counted here; a bound on the count replaces a long repetition.
    logic [7:0]        busyLen_ff, nxt_busyLen;
    always_comb begin
        nxt_busyLen = 8'h00;
        if (state_ff != ACR_ST_IDLE) begin
            nxt_busyLen = busyLen_ff + 8'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busyLen_ff <= 8'h00;
        end else begin
            busyLen_ff <= nxt_busyLen;
        end
    end
    chk_busy_bound: assert property (@(posedge ref_clk) disable iff (srst)
        busyLen_ff <= 8'h41)
        else $error("sequencer busy too long");
    chk_burst_len: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && nxt_state == ACR_ST_CONV && ctrl_ff[`ACR_BIT_BURST])
        |=> ##63 (state_ff == ACR_ST_CONV) ##1 (state_ff == ACR_ST_DONE))
        else $error("burst length wrong");
    chk_busy_flag: assert property (@(posedge ref_clk) disable iff (srst)
        ctrl_ff[`ACR_BIT_BUSY] == (state_ff != ACR_ST_IDLE))
        else $error("busy bit disagrees with sequencer");
    chk_ext_start: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && ctrl_ff[2:0] == 3'h4 && ctrl_ff[7]
         && trigIn.extStart && !extPrev_ff) |=> state_ff == ACR_ST_CONV)
        else $error("external start edge ignored");
    chk_timer_start: assert property (@(posedge ref_clk) disable iff (srst)
        (state_ff == ACR_ST_IDLE && ctrl_ff[2:0] == 3'h1 && ctrl_ff[7] && trigIn.timer0Ovf)
        |=> state_ff == ACR_ST_CONV)
        else $error("timer start ignored");
    // Routing checks look one cycle back because the analog outputs are registered.
    chk_ref_route: assert property (@(posedge ref_clk) disable iff (srst)
        analog_ff.refSel == $past(refCtl_ff[`ACR_REFSEL_LSB +: 2]))
        else $error("reference select not routed");
    chk_level_route: assert property (@(posedge ref_clk) disable iff (srst)
        analog_ff.intRefHigh == $past(refCtl_ff[`ACR_BIT_INTERNAL_REF_LEVEL]))
        else $error("reference level not routed");
    chk_temp_route: assert property (@(posedge ref_clk) disable iff (srst)
        analog_ff.tempSensorOn == $past(refCtl_ff[`ACR_BIT_TEMPEN]))
        else $error("temperature enable not routed");
    chk_analog_ground_pin_select: assert property (@(posedge ref_clk) disable iff (srst)
        analog_ff.useAgndPin == ($past(refCtl_ff[`ACR_BIT_GNDSEL]) && !analog_ff.useChipGnd))
        else $error("analog ground select wrong");
    chk_intref_gnd: assert property (@(posedge ref_clk) disable iff (srst)
        (convActive_ff && analog_ff.refSel == 2'h3 && !analog_ff.intRefHigh) |-> analog_ff.useChipGnd)
        else $error("low internal reference not on chip ground");
    chk_intref_on: assert property (@(posedge ref_clk) disable iff (srst)
        (convActive_ff && analog_ff.refSel == 2'h3) |-> analog_ff.intRefOn)
        else $error("internal reference off during conversion");
    cov_single: cover property (@(posedge ref_clk) state_ff == ACR_ST_DONE && !ctrl_ff[6]);
    cov_burst: cover property (@(posedge ref_clk) state_ff == ACR_ST_DONE && ctrl_ff[6]);
    cov_window: cover property (@(posedge ref_clk) winSet);
    cov_ext: cover property (@(posedge ref_clk) startReq && ctrl_ff[2:0] == 3'h4);
    cov_shutdown: cover property (@(posedge ref_clk) ctrlWr && sfrWdata[4] && !ctrl_ff[7] && !ctrl_ff[6]);
endmodule
`default_nettype wire

// file: testbench/acr_sfr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Register host model
module acr_sfr_host (
    input  wire logic       ref_clk,
    input  wire logic [7:0] sfrRdata,
    output logic      [7:0] sfrAddr,
    output logic      [7:0] sfrWdata,
    output logic            sfrWe
);
    initial begin
        sfrAddr = 8'h00;
        sfrWdata = 8'h00;
        sfrWe = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        sfrAddr = a;
        sfrWdata = d;
        sfrWe = 1'b1;
        @(posedge ref_clk) #1;
        sfrWe = 1'b0;
        // Released data never keeps its last value.
        sfrWdata = ~d;
    endtask
    task automatic present(input logic [7:0] a);
        @(posedge ref_clk) #1;
        sfrAddr = a;
    endtask
    task automatic poll(output bit ok);
        ok = 1'b0;
        present(8'hE8);
        for (int i = 0; i < 300 && !ok; i++) begin
            @(posedge ref_clk) #1;
            ok = (sfrRdata[5] === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/acr_adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acr_adc_control_bench;
    import acr_pkg::*;
    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic [7:0]   sfrAddr, sfrWdata, rdata;
    logic         sfrWe, tempSelected, convActive, sampling, look;
    acr_trig_in_t trigIn;
    logic [15:0]  sampleResult, windowGt, windowLt, result;
    acr_analog_t  analog;
    logic [17:0]  expQ[$];
    logic [17:0]  ex;
    logic [15:0]  got;
    logic [5:0]   v;
    int           num_errors = 0;
    int           total_checks = 0;
    int           cyc = 0;
    bit           ok;
    always #50 ref_clk = ~ref_clk;
    acr_sfr_host host (.ref_clk(ref_clk), .sfrRdata(rdata), .sfrAddr(sfrAddr),
        .sfrWdata(sfrWdata), .sfrWe(sfrWe));
    acr_adc_control dut (.ref_clk(ref_clk), .srst(srst), .sfrAddr(sfrAddr),
        .sfrWdata(sfrWdata), .sfrWe(sfrWe), .sfrRdata_ff(rdata), .trigIn(trigIn),
        .tempSelected(tempSelected), .sampleResult(sampleResult), .windowGt(windowGt),
        .windowLt(windowLt), .result_ff(result), .convActive_ff(convActive),
        .sampling_ff(sampling), .analog_ff(analog));
    // ========================================
    // Checking
    // Kind 0 is read data, 1 the analog controls, 2 the last result, 3 the status pair.
    always @(negedge ref_clk) begin
        if (look) begin
            ex = expQ.pop_front();
            got = (ex[17:16] == 2'h0) ? {8'h00, rdata} :
                  (ex[17:16] == 2'h1) ? {9'h000, analog} :
                  (ex[17:16] == 2'h2) ? result : {14'h0, convActive, sampling};
            total_checks++;
            if (got !== ex[15:0]) begin
                num_errors++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex[15:0]);
            end
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic results;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic note(input logic [1:0] k, input logic [15:0] e);
        expQ.push_back({k, e});
        @(posedge ref_clk) #1;
        look = 1'b1;
        @(posedge ref_clk) #1;
        look = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.present(a);
        note(2'h0, {8'h00, e});
    endtask
    task automatic waitdone;
        host.poll(ok);
        if (!ok) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
    endtask
    // ========================================
    // Tests
    initial begin
        look = 1'b0;
        trigIn = '0;
        tempSelected = 1'b0;
        sampleResult = 16'h0150;
        windowGt = 16'h0100;
        windowLt = 16'h0200;
        void'($urandom(63131));
        repeat (20) @(posedge ref_clk);
        #1 srst = 1'b0;
        rd(8'hE8, 8'h00);
        rd(8'hD1, 8'h00);
        rd(8'h55, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = 6'($urandom);
            tempSelected = v[5];
            host.wr(8'hD1, {3'h0, v[4:0]});
            rd(8'hD1, {3'h0, v[4:0]});
            note(2'h1, {9'h000, v[4:3], 1'b0, v[1], v[2] & ~v[5], v[5], v[0]});
        end
        $display("reference test done");
        tempSelected = 1'b0;
        host.wr(8'hD1, 8'h18);
        // A start is honoured only once enable or burst is already set in the register.
        host.wr(8'hE8, 8'h80);
        host.wr(8'hE8, 8'h90);
        repeat (3) @(posedge ref_clk);
        note(2'h1, 16'h0072);
        note(2'h3, 16'h0002);
        waitdone();
        rd(8'hE8, 8'hA8);
        note(2'h2, 16'h0150);
        note(2'h3, 16'h0001);
        host.wr(8'hE8, 8'h80);
        rd(8'hE8, 8'h80);
        $display("software start test done");
        windowGt = 16'h0200;
        windowLt = 16'h0100;
        for (int t = 1; t < 8; t++) begin
            sampleResult = {8'h00, 8'($urandom)};
            host.wr(8'hE8, {5'h10, 3'(t)});
            @(posedge ref_clk) #1;
            trigIn = (t < 5) ? (4'h8 >> (t - 1)) : 4'hF;
            @(posedge ref_clk) #1;
            trigIn = '0;
            repeat (40) @(posedge ref_clk);
            rd(8'hE8, {2'h2, (t < 5), 1'b0, (t < 5), 3'(t)});
            if (t < 5) note(2'h2, sampleResult);
        end
        $display("trigger test done");
        // Leave the reserved trigger code before the burst start is written.
        host.wr(8'hE8, 8'h40);
        host.wr(8'hE8, 8'h50);
        repeat (40) @(posedge ref_clk);
        rd(8'hE8, 8'h50);
        waitdone();
        rd(8'hE8, 8'h68);
        host.wr(8'hE8, 8'h00);
        host.wr(8'hE8, 8'h10);
        repeat (40) @(posedge ref_clk);
        rd(8'hE8, 8'h00);
        $display("burst and shutdown test done");
        results();
    end
endmodule
`default_nettype wire
